// ===== bfiu_pkg.sv
// Purpose: Shared constants and types for the bit and flag instruction unit.
// Assumes: Single core clock; the decoder presents one operation per cycle.
// Notes:   Flag positions follow the usual eight-bit status register layout.
package bfiu_pkg;

  // Status register bit positions.
  localparam logic [2:0] FLAG_C_POS = 3'h0; // Carry.
  localparam logic [2:0] FLAG_Z_POS = 3'h1; // Zero.
  localparam logic [2:0] FLAG_N_POS = 3'h2; // Negative.
  localparam logic [2:0] FLAG_V_POS = 3'h3; // Overflow.
  localparam logic [2:0] FLAG_S_POS = 3'h4; // Signed test.
  localparam logic [2:0] FLAG_H_POS = 3'h5; // Half carry.
  localparam logic [2:0] FLAG_T_POS = 3'h6; // Bit transfer.
  localparam logic [2:0] FLAG_I_POS = 3'h7; // Global interrupt enable.

  // Reset value of the status register.
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Every operation of this unit except break completes in this many cycles.
  localparam int unsigned OP_CYCLES = 1;

  // Operation codes presented by the decoder.
  typedef enum logic [3:0] {
    BFIU_NOP          = 4'h0, // No operation.
    BFIU_ARITH_SHR    = 4'h1, // Arithmetic shift right.
    BFIU_SWAP         = 4'h2, // Nibble swap.
    BFIU_FLAG_SET_IDX = 4'h3, // Set flag chosen by index.
    BFIU_FLAG_CLR_IDX = 4'h4, // Clear flag chosen by index.
    BFIU_BIT_TO_T     = 4'h5, // Copy register bit into transfer flag.
    BFIU_T_TO_BIT     = 4'h6, // Copy transfer flag into register bit.
    BFIU_FLAG_SET_DED = 4'h7, // Dedicated set opcode for one flag.
    BFIU_FLAG_CLR_DED = 4'h8, // Dedicated clear opcode for one flag.
    BFIU_SLEEP        = 4'h9, // Enter sleep.
    BFIU_WD_RESTART   = 4'ha, // Restart the watchdog.
    BFIU_BREAK        = 4'hb  // Debug break.
  } bfiu_op_e;

  // One request from the decoder.
  typedef struct packed {
    logic       valid;   // Operation present this cycle.
    bfiu_op_e   op;      // Operation code.
    logic [2:0] sel;     // Flag index or bit index.
    logic [7:0] operand; // Register operand value.
  } bfiu_req_s;

  // Result written back to the register file.
  typedef struct packed {
    logic       we;   // Write enable, one cycle.
    logic [7:0] data; // Result byte.
  } bfiu_wb_s;

endpackage : bfiu_pkg

// ===== bfiu_alu.sv
// Purpose: Combinational result and flag logic for one operation.
// Assumes: Request fields are stable while valid is high.
// Notes:   Pure logic; the top registers what it produces.
module bfiu_alu
  import bfiu_pkg::*;
(
  input  bfiu_pkg::bfiu_req_s req,        // Decoder request.
  input  logic [7:0]          status_in,  // Current status register.
  output logic [7:0]          status_out, // Status register after the operation.
  output logic                wr_en,      // Register write-back wanted.
  output logic [7:0]          wr_data     // Register write-back value.
);

  logic [7:0] shifted; // Arithmetic right shift of the operand.
  logic       res_n;   // Negative of the shift result.
  logic       res_c;   // Bit shifted out.

  assign shifted = {req.operand[7], req.operand[7:1]};
  assign res_n   = shifted[7];
  assign res_c   = req.operand[0];

  // Compute the result for the requested operation; defaults leave state alone.
  always_comb begin
    status_out = status_in;
    wr_en      = 1'b0;
    wr_data    = req.operand;
    if (req.valid) begin
      case (req.op)
        BFIU_ARITH_SHR: begin // [RQ1]
          wr_en                  = 1'b1;
          wr_data                = shifted;
          status_out[FLAG_Z_POS] = (shifted == 8'h00);
          status_out[FLAG_C_POS] = res_c;
          status_out[FLAG_N_POS] = res_n;
          // Overflow is negative xor carry after the shift.
          status_out[FLAG_V_POS] = res_n ^ res_c;
        end
        BFIU_SWAP: begin // [RQ2]
          wr_en   = 1'b1;
          wr_data = {req.operand[3:0], req.operand[7:4]};
        end
        // Index and dedicated forms share one path, touching only one bit.
        BFIU_FLAG_SET_IDX, BFIU_FLAG_SET_DED: begin // [RQ3] [RQ6] [RQ7] [RQ11]
          status_out[req.sel] = 1'b1;
        end
        BFIU_FLAG_CLR_IDX, BFIU_FLAG_CLR_DED: begin // [RQ3] [RQ6] [RQ7] [RQ11]
          status_out[req.sel] = 1'b0;
        end
        BFIU_BIT_TO_T: begin // [RQ4]
          status_out[FLAG_T_POS] = req.operand[req.sel];
        end
        BFIU_T_TO_BIT: begin // [RQ5]
          wr_en                = 1'b1;
          wr_data[req.sel]     = status_in[FLAG_T_POS];
        end
        default: begin
          // No operation, sleep, watchdog and break change nothing here.
          status_out = status_in;
        end
      endcase
    end
  end

endmodule // bfiu_alu

// ===== bfiu_top.sv
// Purpose: Bit, flag and core-control instruction unit of an eight-bit core.
// Assumes: Decoder issues at most one operation per cycle, synchronous to I_CLK.
// Notes:   All operations except break retire in one cycle; results are registered.
//
// Overview of operation
// RQ1 - Arithmetic shift right keeps bit seven, sets ZCNV
// RQ2 - Nibble swap in one cycle, flags untouched
// RQ3 - Set or clear one flag by index
// RQ4 - Copy chosen register bit into transfer flag
// RQ5 - Write transfer flag into chosen register bit
// RQ6 - Dedicated set and clear of half carry
// RQ7 - Dedicated set and clear of signed test
// RQ8 - Sleep takes one cycle, hands to power management
// RQ9 - Watchdog restart pulse, one cycle, no flags
// RQ10 - Break only signals debug, flags untouched
// RQ11 - Dedicated global interrupt enable set and clear
// RQ12 - No operation changes nothing for one cycle
module bfiu_top
  import bfiu_pkg::*;
(
  input  logic                I_CLK,          // Core clock, 40 MHz.
  input  logic                I_RESET_N,      // Asynchronous reset, active low.
  input  bfiu_pkg::bfiu_req_s I_REQ,          // Operation from the decoder.
  output bfiu_pkg::bfiu_wb_s  O_WB,           // Register write-back.
  output logic [7:0]          O_STATUS,       // Status register contents.
  output logic                O_IRQ_ENABLE,   // Global interrupt enable level.
  output logic                O_SLEEP_REQ,    // Sleep request pulse.
  output logic                O_WD_RESTART,   // Watchdog restart pulse.
  output logic                O_BREAK_REQ,    // Debug break pulse.
  output logic                O_DONE          // Operation retired pulse.
);

  logic [7:0] status_reg;  // Status register.
  logic [7:0] status_next; // Its next value.
  logic       wr_en;       // Write-back wanted this cycle.
  logic [7:0] wr_data;     // Write-back value.
  bfiu_wb_s   wb_reg;      // Registered write-back.
  logic       sleep_reg;   // Sleep pulse.
  logic       wd_rst_reg;  // Watchdog restart pulse.
  logic       brk_reg;     // Break pulse.
  logic       done_reg;    // Retire pulse.

  // Result logic lives apart so the sequencing here stays easy to read.
  bfiu_alu u_alu (
    .req        (I_REQ),
    .status_in  (status_reg),
    .status_out (status_next),
    .wr_en      (wr_en),
    .wr_data    (wr_data)
  );

  // Status register update, one cycle per operation.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next; // [RQ3]
    end
  end

  // Register write-back so the file sees a clean one-cycle strobe.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wb_reg <= '0;
    end else begin
      wb_reg.we   <= wr_en; // [RQ1] [RQ2] [RQ5]
      wb_reg.data <= wr_data;
    end
  end

  // Control pulses to sleep, watchdog and debug logic.
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sleep_reg <= 1'b0;
      wd_rst_reg <= 1'b0;
      brk_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      sleep_reg <= I_REQ.valid && (I_REQ.op == BFIU_SLEEP);      // [RQ8]
      wd_rst_reg <= I_REQ.valid && (I_REQ.op == BFIU_WD_RESTART); // [RQ9]
      // Break retires only when the debug logic takes it, so no done pulse.
      brk_reg   <= I_REQ.valid && (I_REQ.op == BFIU_BREAK);      // [RQ10]
      done_reg  <= I_REQ.valid && (I_REQ.op != BFIU_BREAK);      // [RQ12]
    end
  end

  assign O_WB         = wb_reg;
  assign O_STATUS     = status_reg;
  assign O_IRQ_ENABLE = status_reg[FLAG_I_POS]; // [RQ11]
  assign O_SLEEP_REQ  = sleep_reg;
  assign O_WD_RESTART = wd_rst_reg;
  assign O_BREAK_REQ  = brk_reg;
  assign O_DONE       = done_reg;

  // Assertions.
  a_shift_result: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_ARITH_SHR |=> O_WB.we &&
    O_WB.data == {$past(I_REQ.operand[7]), $past(I_REQ.operand[7:1])} &&
    O_STATUS[FLAG_C_POS] == $past(I_REQ.operand[0]))
    else $error("Shift result or carry wrong."); // [RQ1]
  a_swap_flags: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_SWAP |=> $stable(O_STATUS) &&
    O_WB.data == {$past(I_REQ.operand[3:0]), $past(I_REQ.operand[7:4])})
    else $error("Swap wrong or flags moved."); // [RQ2]
  a_flag_set_one: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && (I_REQ.op == BFIU_FLAG_SET_IDX || I_REQ.op == BFIU_FLAG_SET_DED)
    |=> O_STATUS == ($past(O_STATUS) | (8'h01 << $past(I_REQ.sel))))
    else $error("Flag set touched other bits."); // [RQ3]
  a_flag_clr_one: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && (I_REQ.op == BFIU_FLAG_CLR_IDX || I_REQ.op == BFIU_FLAG_CLR_DED)
    |=> O_STATUS == ($past(O_STATUS) & ~(8'h01 << $past(I_REQ.sel))))
    else $error("Flag clear touched other bits."); // [RQ3] [RQ6] [RQ7]
  a_bit_to_t: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_BIT_TO_T |=> !O_WB.we &&
    O_STATUS[FLAG_T_POS] == $past(I_REQ.operand[I_REQ.sel]))
    else $error("Transfer flag not loaded."); // [RQ4]
  a_t_to_bit: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_T_TO_BIT |=> $stable(O_STATUS) &&
    O_WB.data[$past(I_REQ.sel)] == O_STATUS[FLAG_T_POS])
    else $error("Bit load wrong."); // [RQ5]
  a_sleep_pulse: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_SLEEP |=> O_SLEEP_REQ && $stable(O_STATUS))
    else $error("Sleep pulse missing."); // [RQ8]
  a_wdr_pulse: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_WD_RESTART |=> O_WD_RESTART && $stable(O_STATUS))
    else $error("Watchdog pulse missing."); // [RQ9]
  a_break_flags: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_BREAK |=> O_BREAK_REQ && !O_DONE && $stable(O_STATUS))
    else $error("Break misbehaved."); // [RQ10]
  a_irq_follow: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_FLAG_SET_DED && I_REQ.sel == FLAG_I_POS |=> O_IRQ_ENABLE)
    else $error("Interrupt enable not set."); // [RQ11]
  a_nop_quiet: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_NOP |=> O_DONE && !O_WB.we && $stable(O_STATUS))
    else $error("No operation changed state."); // [RQ12]

  // The shift flags follow from the written result; the upper four flags must not move.
  a_shift_flags: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_ARITH_SHR |=>
    O_STATUS[FLAG_Z_POS] == (O_WB.data == 8'h00) && O_STATUS[FLAG_N_POS] == O_WB.data[7] &&
    O_STATUS[FLAG_V_POS] == (O_WB.data[7] ^ O_STATUS[FLAG_C_POS]) &&
    O_STATUS[7:4] == $past(O_STATUS[7:4]))
    else $error("Shift flags wrong."); // [RQ1]

  // A sleep pulse without a sleep request would stall the core for nothing.
  a_sleep_only: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    !(I_REQ.valid && I_REQ.op == BFIU_SLEEP) |=> !O_SLEEP_REQ)
    else $error("Stray sleep pulse."); // [RQ8]

  // A stray restart would hide a hung program from the watchdog.
  a_wd_only: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    !(I_REQ.valid && I_REQ.op == BFIU_WD_RESTART) |=> !O_WD_RESTART)
    else $error("Stray watchdog pulse."); // [RQ9]

  // Break must neither write back nor retire in this unit.
  a_break_no_wb: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_BREAK |=> !O_WB.we)
    else $error("Break wrote a register."); // [RQ10]

  // The interrupt logic must see the enable drop right after the clear.
  a_irq_clear: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    I_REQ.valid && I_REQ.op == BFIU_FLAG_CLR_DED && I_REQ.sel == FLAG_I_POS |=> !O_IRQ_ENABLE)
    else $error("Interrupt enable not cleared."); // [RQ11]

  // With no request the unit holds the status and stays silent.
  a_idle_hold: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    !I_REQ.valid |=> $stable(O_STATUS) && !O_WB.we && !O_DONE)
    else $error("Idle cycle changed state."); // [RQ12]

  // Main scenarios worth seeing at least once.
  c_shift: cover property (@(posedge I_CLK) I_REQ.valid && I_REQ.op == BFIU_ARITH_SHR);
  c_swap:  cover property (@(posedge I_CLK) I_REQ.valid && I_REQ.op == BFIU_SWAP);
  c_t_rt:  cover property (@(posedge I_CLK) I_REQ.valid && I_REQ.op == BFIU_BIT_TO_T
                            ##1 I_REQ.valid && I_REQ.op == BFIU_T_TO_BIT);
  c_sleep: cover property (@(posedge I_CLK) O_SLEEP_REQ);
  c_break: cover property (@(posedge I_CLK) O_BREAK_REQ);

endmodule // bfiu_top

// ===== bfiu_regfile_model.sv
// Purpose: Register-file partner that feeds operands to the unit and takes its write-backs.
// Assumes: Write-back strobe is a one-cycle pulse on the rising clock edge.
// Notes:   One register is enough, since each operation reads and writes one byte.
module bfiu_regfile_model
  import bfiu_pkg::*;
(
  input  wire logic               i_clk,     // Core clock.
  input  wire logic               i_reset_n, // Asynchronous reset, active low.
  input  wire bfiu_pkg::bfiu_wb_s i_wb,      // Write-back from the unit.
  output logic [7:0]              o_reg      // Register value offered as operand.
);
  import bfiu_pkg::*;
  logic [7:0] reg_q; // Modelled destination register.
  assign o_reg = reg_q;

  // Captures the write-back; a plain always block lets the bench preload the register too.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reg_q <= 8'h00;
    end else if (i_wb.we) begin
      reg_q <= i_wb.data;
    end
  end

  // Preloads the register between clock edges, as a load instruction of the core would.
  task automatic set_reg(input logic [7:0] v);
    reg_q = v;
  endtask
endmodule // bfiu_regfile_model

// ===== bfiu_top_bench.sv
// Purpose: Self-checking bench for the bit, flag and core-control instruction unit.
// Assumes: One request per cycle; outputs settle one cycle after the request is taken.
// Notes:   Expected status is tracked in the bench, independent of the design.
module bfiu_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bfiu_pkg::*;
  logic       I_CLK = 1'b0, I_RESET_N = 1'b0, O_IRQ_ENABLE, O_SLEEP_REQ, O_WD_RESTART, O_BREAK_REQ, O_DONE;
  bfiu_req_s  I_REQ = '0;        // Request toward the unit.
  bfiu_wb_s   O_WB;              // Write-back seen from the unit.
  logic [7:0] O_STATUS, reg_val; // Status output and modelled register.
  logic [7:0] exp_st = 8'h00;    // Status expected by the bench.
  int         mismatches = 0, samples_checked = 0;

  bfiu_top uut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_REQ(I_REQ), .O_WB(O_WB), .O_STATUS(O_STATUS),
    .O_IRQ_ENABLE(O_IRQ_ENABLE), .O_SLEEP_REQ(O_SLEEP_REQ), .O_WD_RESTART(O_WD_RESTART),
    .O_BREAK_REQ(O_BREAK_REQ), .O_DONE(O_DONE));
  bfiu_regfile_model rf (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_wb(O_WB), .o_reg(reg_val));

  // Half-period toggle gives 25 ns.
  always #12.5 I_CLK = ~I_CLK;

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Preloads the register one edge later, so a pending write-back cannot overwrite it.
  task automatic load(input logic [7:0] v);
    @(posedge I_CLK);
    #1 rf.set_reg(v);
  endtask

  // Issues one operation with the register as operand and checks its retirement.
  task automatic do_op(input bfiu_op_e op, input logic [2:0] sel);
    @(posedge I_CLK);
    #1 I_REQ = '{valid: 1'b1, op: op, sel: sel, operand: reg_val};
    @(posedge I_CLK);
    #1 I_REQ.valid = 1'b0;
    chk(O_DONE, op != BFIU_BREAK, "done pulse");
  endtask

  // Every flag set then cleared by index, then the dedicated opcodes for H, S and I.
  task automatic t_flags();
    for (int i = 0; i < 16; i++) begin
      do_op(i < 8 ? BFIU_FLAG_SET_IDX : BFIU_FLAG_CLR_IDX, 3'(i));
      exp_st[i % 8] = (i < 8);
      chk(O_STATUS, exp_st, "flag by index");
    end
    foreach (exp_st[i]) begin
      if (i == FLAG_H_POS || i == FLAG_S_POS || i == FLAG_I_POS) begin
        do_op(BFIU_FLAG_SET_DED, 3'(i));
        exp_st[i] = 1'b1;
        chk({O_IRQ_ENABLE, O_STATUS}, {exp_st[7], exp_st}, "dedicated set");
      end
    end
    do_op(BFIU_FLAG_CLR_DED, FLAG_I_POS);
    exp_st[FLAG_I_POS] = 1'b0;
    chk({O_IRQ_ENABLE, O_STATUS}, {1'b0, exp_st}, "dedicated clear");
    do_op(BFIU_FLAG_CLR_DED, FLAG_H_POS);
    exp_st[FLAG_H_POS] = 1'b0;
    chk(O_STATUS, exp_st, "clear half carry");
    do_op(BFIU_FLAG_CLR_DED, FLAG_S_POS);
    exp_st[FLAG_S_POS] = 1'b0;
    chk(O_STATUS, exp_st, "clear signed test");
    $display("Test flags done");
  endtask

  // Shift keeps bit 7 and sets Z, C, N and V; S and H stay as they were.
  task automatic t_shift();
    logic [7:0] d[3] = '{8'h81, 8'h01, 8'h7e};
    logic [7:0] r;
    foreach (d[k]) begin
      load(d[k]);
      r = {d[k][7], d[k][7:1]};
      exp_st[FLAG_C_POS] = d[k][0];
      exp_st[FLAG_Z_POS] = (r == 8'h00);
      exp_st[FLAG_N_POS] = r[7];
      exp_st[FLAG_V_POS] = r[7] ^ d[k][0];
      do_op(BFIU_ARITH_SHR, 3'h0);
      chk({O_WB, O_STATUS}, {1'b1, r, exp_st}, "shift result");
    end
    $display("Test shift done");
  endtask

  // Swap twice through the register file; flags never move.
  task automatic t_swap();
    load(8'ha5);
    do_op(BFIU_SWAP, 3'h0);
    chk({O_WB.data, O_STATUS}, {8'h5a, exp_st}, "first swap");
    do_op(BFIU_SWAP, 3'h0);
    chk({O_WB.data, O_STATUS}, {8'ha5, exp_st}, "second swap");
    $display("Test swap done");
  endtask

  // Bit goes to T and back into another position; only T or one bit changes.
  task automatic t_bits();
    load(8'h10);
    do_op(BFIU_BIT_TO_T, 3'h4);
    exp_st[FLAG_T_POS] = 1'b1;
    chk({O_WB.we, O_STATUS}, {1'b0, exp_st}, "bit into T");
    load(8'h01);
    do_op(BFIU_T_TO_BIT, 3'h7);
    chk({O_WB, O_STATUS}, {1'b1, 8'h81, exp_st}, "T into bit");
    do_op(BFIU_BIT_TO_T, 3'h3);
    exp_st[FLAG_T_POS] = 1'b0;
    chk(O_STATUS, exp_st, "clear T");
    $display("Test bits done");
  endtask

  // Sleep, restart and break give their own pulse for one cycle; all four control operations leave state alone.
  task automatic t_ctrl();
    bfiu_op_e ops[4] = '{BFIU_NOP, BFIU_SLEEP, BFIU_WD_RESTART, BFIU_BREAK};
    foreach (ops[k]) begin
      do_op(ops[k], 3'h0);
      chk({O_SLEEP_REQ, O_WD_RESTART, O_BREAK_REQ, O_WB.we, O_STATUS},
          {ops[k] == BFIU_SLEEP, ops[k] == BFIU_WD_RESTART, ops[k] == BFIU_BREAK, 1'b0, exp_st}, "control");
      @(posedge I_CLK);
      #1 chk({O_SLEEP_REQ, O_WD_RESTART, O_BREAK_REQ, O_DONE}, 4'h0, "pulse width");
    end
    $display("Test control done");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence: two-cycle reset, scenarios, then a reset in mid-run.
  initial begin
    repeat (2) @(posedge I_CLK);
    #1 I_RESET_N = 1'b1;
    chk(O_STATUS, 8'h00, "status after reset");
    t_flags();
    t_shift();
    t_swap();
    t_bits();
    t_ctrl();
    #3 I_RESET_N = 1'b0;
    #1 chk({O_STATUS, O_IRQ_ENABLE}, 9'h000, "mid-run reset");
    finish_test();
  end

  // The run needs about 80 cycles; 20 us is ample margin.
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
endmodule // bfiu_top_bench
